// ### common/srstc_consts.vh
// constants for the system reset controller
`ifndef SRSTC_CONSTS_VH
`define SRSTC_CONSTS_VH
// reset-cause flag positions
`define SRSTC_CAUSE_EXT 0
`define SRSTC_CAUSE_POR 1
`define SRSTC_CAUSE_BOR 2
`define SRSTC_CAUSE_WDT 3
`define SRSTC_CAUSE_SW 4
`define SRSTC_CAUSE_OSC 5
`define SRSTC_CAUSE_W 6
// reset value of the cause flags: power-on only
`define SRSTC_CAUSE_POR_ONLY 6'h02
// peripheral reset register width
`define SRSTC_PERIPH_W 32
// hold counter end value; internal reset stays in the hold state 9 cycles after all sources drop
`define SRSTC_HOLD_CYC 4'h8
// boot fetch sequence states
`define SRSTC_ST_RESET 3'h0
`define SRSTC_ST_HOLD 3'h1
`define SRSTC_ST_FETCH_SP 3'h2
`define SRSTC_ST_FETCH_PC 3'h3
`define SRSTC_ST_FETCH_INS 3'h4
`define SRSTC_ST_RUN 3'h5
// arbitrary identification values
`define SRSTC_IDENT_0 32'h10010000
`define SRSTC_IDENT_1 32'h10FF0000
`endif

// ### rtl/srstc_top.v
// system reset controller: source collection, cause flags, release and boot fetch sequencing
// Overview of operation
// - six sources (pin, power-on, brown-out, software, watchdog, oscillator fail) drive internal reset
// - cause flag set for each reset source; flags sticky across later resets
// - power-on cause clears all other cause flags, leaving only power-on
// - pin reset resets core and peripherals but not the test access port
// - a few cycles of pin synchronization precede internal reset release
// - after release, fetch stack pointer, then program counter, then first instruction, then run
// - at power-up internal reset holds until both pin and power-on are inactive
// - power-on indication is active only during initial power-up
// - power-on also resets test access port; pin reset does not
// - brown-out reset disabled after reset until software enables it
// - brown-out raises an interrupt or a reset, depending on configuration
// - brown-out resets only when the brown-out reset enable bit is set
// - brown-out reset acts like pin reset, held while supply stays low
// - setting then clearing a peripheral reset bit resets that peripheral
// - peripheral reset bit positions match clock-gating bit positions
// - peripheral software reset asserts resets of all its clock domains
// - system reset request resets whole system including core, then boots
// - watchdog interrupts on first time-out and requests reset on second
// - after first time-out the 32-bit counter reloads from reload value
// - second zero with interrupt uncleared and reset enabled asserts system reset
// - seven read-only identification registers report version, part, sizes, features; here two ident, three capability, one cause and one power-on word
// - oscillator failure detection active only when check enable is set
// - oscillator failure recorded in a dedicated flag of the cause register
// - after oscillator-fail reset, control passes to the non-maskable interrupt handler
`timescale 1ns/1ps
`include "srstc_consts.vh"
module srstc_top (
  // clock and asynchronous power-on reset
  input wire mclk,
  input wire reset_n,
  // external reset pin and power detectors
  input wire rst_pin_n,
  input wire brownout_low,
  // brownout_reset_control fields
  input wire brownout_reset_enable,
  input wire brownout_int_enable,
  // software sources
  input wire system_reset_request,
  input wire [`SRSTC_PERIPH_W-1:0] peripheral_reset_regs_0,
  input wire [`SRSTC_PERIPH_W-1:0] peripheral_reset_regs_1,
  input wire [`SRSTC_PERIPH_W-1:0] peripheral_reset_regs_2,
  // watchdog
  input wire [31:0] watchdog_reload_value,
  input wire wdt_enable,
  input wire wdt_reset_enable,
  input wire wdt_int_clear,
  // main oscillator check
  input wire osc_check_enable,
  input wire main_osc_bad,
  // cause register clear (software writes zeros)
  input wire cause_clear,
  input wire [`SRSTC_CAUSE_W-1:0] cause_clear_mask,
  // identification select
  input wire [2:0] ident_sel,
  // boot fetch handshake with the core
  input wire fetch_done,
  // reset outputs
  output wire core_reset_n,
  output wire jtag_reset_n,
  output wire [`SRSTC_PERIPH_W-1:0] periph_reset_0_n,
  output wire [`SRSTC_PERIPH_W-1:0] periph_reset_1_n,
  output wire [`SRSTC_PERIPH_W-1:0] periph_reset_2_n,
  // status and core steering
  output reg [`SRSTC_CAUSE_W-1:0] reset_cause_reg,
  output reg [2:0] boot_state,
  output reg nmi_boot,
  output reg brownout_int,
  output reg wdt_int,
  output reg [31:0] wdt_count,
  output reg [31:0] ident_data
);
  // power-on resets test access port too; pin reset leaves it alone
  assign jtag_reset_n = reset_n;

  // two-stage synchronizers for pin and power-on release
  // both stages clear on power-on, so release waits for two clean edges
  reg pin_s1;
  reg pin_s2;
  reg por_s1;
  reg por_s2;
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      pin_s1 <= 1'b0;
      pin_s2 <= 1'b0;
      por_s1 <= 1'b0;
      por_s2 <= 1'b0;
    end else begin
      pin_s1 <= rst_pin_n;
      pin_s2 <= pin_s1;
      por_s1 <= 1'b1;
      por_s2 <= por_s1;
    end
  end

  // power-on indication only from the initial power-up until first release
  reg por_active;
  // watchdog second time-out pulse and oscillator fail level
  reg wdt_fire;
  wire osc_fail = osc_check_enable & main_osc_bad;
  wire bor_rst = brownout_reset_enable & brownout_low;
  // any source drives the common internal reset
  wire any_src = ~pin_s2 | ~por_s2 | bor_rst | system_reset_request | wdt_fire | osc_fail;

  // brown-out interrupt path when reset is not selected
  // detector output taken as synchronous; a glitch shorter than a cycle is missed
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      brownout_int <= 1'b0;
    end else begin
      brownout_int <= brownout_low & ~brownout_reset_enable & brownout_int_enable;
    end
  end

  // cause flags: sticky, set wins over software clear
  function [`SRSTC_CAUSE_W-1:0] cause_bits;
    input ext;
    input bor;
    input wdt;
    input sw;
    input osc;
    begin
      cause_bits = {`SRSTC_CAUSE_W{1'b0}};
      cause_bits[`SRSTC_CAUSE_EXT] = ext;
      cause_bits[`SRSTC_CAUSE_BOR] = bor;
      cause_bits[`SRSTC_CAUSE_WDT] = wdt;
      cause_bits[`SRSTC_CAUSE_SW] = sw;
      cause_bits[`SRSTC_CAUSE_OSC] = osc;
    end
  endfunction

  // a pin held through power-up belongs to power-on, so it leaves no pin flag
  wire [`SRSTC_CAUSE_W-1:0] set_bits = cause_bits(~pin_s2 & ~bor_rst & ~por_active, bor_rst, wdt_fire,
    system_reset_request, osc_fail);
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      // power-on leaves only its own indicator
      reset_cause_reg <= `SRSTC_CAUSE_POR_ONLY;
    end else begin
      reset_cause_reg <= (reset_cause_reg & ~({`SRSTC_CAUSE_W{cause_clear}} & cause_clear_mask))
        | set_bits;
    end
  end

  // release hold counter and boot fetch sequence
  // the hold gives supplies and clocks time to settle before the first fetch
  reg [3:0] hold_cnt;
  reg [2:0] next_boot_state;
  always @* begin
    next_boot_state = boot_state;
    case (boot_state)
      `SRSTC_ST_RESET: begin
        if (!any_src) begin
          next_boot_state = `SRSTC_ST_HOLD;
        end
      end
      `SRSTC_ST_HOLD: begin
        if (any_src) begin
          next_boot_state = `SRSTC_ST_RESET;
        end else if (hold_cnt == `SRSTC_HOLD_CYC) begin
          next_boot_state = `SRSTC_ST_FETCH_SP;
        end
      end
      `SRSTC_ST_FETCH_SP: begin
        if (fetch_done) begin
          next_boot_state = `SRSTC_ST_FETCH_PC;
        end
      end
      `SRSTC_ST_FETCH_PC: begin
        if (fetch_done) begin
          next_boot_state = `SRSTC_ST_FETCH_INS;
        end
      end
      `SRSTC_ST_FETCH_INS: begin
        if (fetch_done) begin
          next_boot_state = `SRSTC_ST_RUN;
        end
      end
      `SRSTC_ST_RUN: begin
        next_boot_state = `SRSTC_ST_RUN;
      end
      default: begin
        next_boot_state = `SRSTC_ST_RESET;
      end
    endcase
    // any source during fetch or run restarts the sequence
    if (any_src) begin
      next_boot_state = `SRSTC_ST_RESET;
    end
  end

  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      boot_state <= `SRSTC_ST_RESET;
      hold_cnt <= 4'h0;
      por_active <= 1'b1;
      nmi_boot <= 1'b0;
    end else begin
      boot_state <= next_boot_state;
      if (boot_state == `SRSTC_ST_HOLD && !any_src) begin
        hold_cnt <= hold_cnt + 4'h1;
      end else begin
        hold_cnt <= 4'h0;
      end
      if (next_boot_state == `SRSTC_ST_FETCH_SP) begin
        por_active <= 1'b0;
      end
      // oscillator-fail reset steers the first fetch to the nmi handler
      // dropped once the core runs, so a later reset boots normally
      if (osc_fail) begin
        nmi_boot <= 1'b1;
      end else if (boot_state == `SRSTC_ST_RUN) begin
        nmi_boot <= 1'b0;
      end
    end
  end

  // core held until sequence leaves reset and hold
  // decoded from the state register only, so source glitches never reach the core
  wire sys_rst = (boot_state == `SRSTC_ST_RESET) || (boot_state == `SRSTC_ST_HOLD);
  assign core_reset_n = ~sys_rst;

  // peripheral resets: system reset or a pulse on set-then-clear of its bit
  // limitation: a bit set and cleared within one cycle is never seen
  reg [`SRSTC_PERIPH_W-1:0] prev_0;
  reg [`SRSTC_PERIPH_W-1:0] prev_1;
  reg [`SRSTC_PERIPH_W-1:0] prev_2;
  reg [`SRSTC_PERIPH_W-1:0] pulse_0;
  reg [`SRSTC_PERIPH_W-1:0] pulse_1;
  reg [`SRSTC_PERIPH_W-1:0] pulse_2;
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      prev_0 <= 32'h00000000;
      prev_1 <= 32'h00000000;
      prev_2 <= 32'h00000000;
      pulse_0 <= 32'h00000000;
      pulse_1 <= 32'h00000000;
      pulse_2 <= 32'h00000000;
    end else begin
      prev_0 <= peripheral_reset_regs_0;
      prev_1 <= peripheral_reset_regs_1;
      prev_2 <= peripheral_reset_regs_2;
      // falling edge of each bit gives one reset cycle
      pulse_0 <= prev_0 & ~peripheral_reset_regs_0;
      pulse_1 <= prev_1 & ~peripheral_reset_regs_1;
      pulse_2 <= prev_2 & ~peripheral_reset_regs_2;
    end
  end
  // same bit order as clock gating; one line per unit covers all its clock domains
  assign periph_reset_0_n = ~(pulse_0 | {`SRSTC_PERIPH_W{sys_rst}});
  assign periph_reset_1_n = ~(pulse_1 | {`SRSTC_PERIPH_W{sys_rst}});
  assign periph_reset_2_n = ~(pulse_2 | {`SRSTC_PERIPH_W{sys_rst}});

  // watchdog: interrupt at first zero, reset at second while interrupt uncleared
  // reloading during system reset keeps a stale count from firing right after boot
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      wdt_count <= 32'hFFFFFFFF;
      wdt_int <= 1'b0;
      wdt_fire <= 1'b0;
    end else if (sys_rst) begin
      wdt_count <= watchdog_reload_value;
      wdt_int <= 1'b0;
      wdt_fire <= 1'b0;
    end else if (wdt_enable) begin
      wdt_fire <= 1'b0;
      if (wdt_count == 32'h00000000) begin
        wdt_count <= watchdog_reload_value;
        if (wdt_int && wdt_reset_enable) begin
          wdt_fire <= 1'b1;
        end
        wdt_int <= 1'b1; // set wins over clear
      end else begin
        wdt_count <= wdt_count - 32'h00000001;
        if (wdt_int_clear) begin
          wdt_int <= 1'b0;
        end
      end
    end else if (wdt_int_clear) begin
      wdt_int <= 1'b0;
    end
  end

  // read-only identification: two ident words and capability words
  // one cycle of latency: the word follows the select on the next edge
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      ident_data <= 32'h00000000;
    end else begin
      case (ident_sel)
        3'h0: ident_data <= `SRSTC_IDENT_0;
        3'h1: ident_data <= `SRSTC_IDENT_1;
        3'h2: ident_data <= {26'h0000000, reset_cause_reg};
        3'h3: ident_data <= 32'h0000FFFF; // arbitrary capability value
        3'h4: ident_data <= 32'h00FF00FF; // arbitrary capability value
        3'h5: ident_data <= 32'h000000FF; // arbitrary capability value
        3'h6: ident_data <= {31'h00000000, por_active};
        default: ident_data <= 32'h00000000;
      endcase
    end
  end
endmodule

// ### tb/srstc_core_model.sv
// core-side partner answering each boot fetch after a chosen delay
`timescale 1ns/1ps
`include "srstc_consts.vh"
module srstc_core_model (
  // clock and reset
  input wire mclk,
  input wire reset_n,
  // fetch request and answer delay
  input wire [2:0] boot_state,
  input wire [1:0] lat,
  // answer
  output reg fetch_done
);
  reg [1:0] cnt;
  // one answer per fetch step; silent outside fetch states
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      fetch_done <= 1'b0;
      cnt <= 2'h0;
    end else if (fetch_done || boot_state < `SRSTC_ST_FETCH_SP || boot_state > `SRSTC_ST_FETCH_INS) begin
      fetch_done <= 1'b0;
      cnt <= 2'h0;
    end else if (cnt == lat) begin
      fetch_done <= 1'b1;
    end else begin
      cnt <= cnt + 2'h1;
    end
  end
endmodule

// ### tb/srstc_top_monitor.sv
// assertion checker on the reset controller ports
`timescale 1ns/1ps
`include "srstc_consts.vh"
module srstc_top_monitor (
  // clock and resets
  input wire mclk,
  input wire reset_n,
  input wire rst_pin_n,
  // sources
  input wire brownout_low,
  input wire brownout_reset_enable,
  input wire system_reset_request,
  input wire osc_check_enable,
  input wire [`SRSTC_PERIPH_W-1:0] peripheral_reset_regs_0,
  // watched outputs
  input wire core_reset_n,
  input wire jtag_reset_n,
  input wire [`SRSTC_PERIPH_W-1:0] periph_reset_0_n,
  input wire [`SRSTC_CAUSE_W-1:0] reset_cause_reg,
  input wire [2:0] boot_state
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  // fetch steps, each leaving for the next or back to reset
  sequence s_left_sp;
    boot_state == `SRSTC_ST_FETCH_SP ##1 boot_state != `SRSTC_ST_FETCH_SP;
  endsequence
  sequence s_left_pc;
    boot_state == `SRSTC_ST_FETCH_PC ##1 boot_state != `SRSTC_ST_FETCH_PC;
  endsequence
  a_sp_then_pc: assert property (s_left_sp |-> boot_state inside {`SRSTC_ST_FETCH_PC, `SRSTC_ST_RESET})
    else $error("stack pointer fetch not followed by counter fetch");
  a_pc_then_ins: assert property (s_left_pc |-> boot_state inside {`SRSTC_ST_FETCH_INS, `SRSTC_ST_RESET})
    else $error("counter fetch not followed by instruction fetch");
  a_core_follows_state: assert property (core_reset_n == !(boot_state inside {`SRSTC_ST_RESET, `SRSTC_ST_HOLD}))
    else $error("core reset disagrees with sequencer state");
  a_jtag_pin_scope: assert property (jtag_reset_n)
    else $error("test port reset outside power-on");
  a_pin_resets_core: assert property (!rst_pin_n [*4] |=> !core_reset_n)
    else $error("pin low did not reset core");
  a_pin_sync_hold: assert property ($rose(rst_pin_n) |-> !core_reset_n [*3])
    else $error("core released too soon after pin");
  a_por_release: assert property (($rose(reset_n) && rst_pin_n) |->
    !core_reset_n [*8] ##[1:12] core_reset_n)
    else $error("power-on release timing wrong");
  a_por_no_ext: assert property ($rose(reset_n) |-> !reset_cause_reg[`SRSTC_CAUSE_EXT] [*8])
    else $error("pin flag raised during power-up");
  a_bor_resets: assert property ((brownout_low && brownout_reset_enable) [*4] |=> !core_reset_n)
    else $error("enabled brown-out did not reset");
  a_bor_gated: assert property ($rose(reset_cause_reg[`SRSTC_CAUSE_BOR]) |-> $past(brownout_reset_enable, 3))
    else $error("brown-out flag set while disabled");
  a_sw_request: assert property (system_reset_request [*4] |=> !core_reset_n)
    else $error("system request did not reset core");
  a_osc_gated: assert property (!osc_check_enable [*4] |=> !$rose(reset_cause_reg[`SRSTC_CAUSE_OSC]))
    else $error("oscillator flag set while check off");
  a_periph_pulse: assert property ($fell(peripheral_reset_regs_0[0]) |-> ##[0:3] !periph_reset_0_n[0])
    else $error("peripheral reset pulse missing");
endmodule
bind srstc_top srstc_top_monitor mon_u (.mclk, .reset_n, .rst_pin_n, .brownout_low, .brownout_reset_enable,
  .system_reset_request, .osc_check_enable, .peripheral_reset_regs_0, .core_reset_n, .jtag_reset_n,
  .periph_reset_0_n, .reset_cause_reg, .boot_state);

// ### tb/srstc_top_tb_top.sv
// self-checking bench for the system reset controller
`timescale 1ns/1ps
`include "srstc_consts.vh"
module srstc_top_tb_top;
  reg mclk = 1'b0, reset_n = 1'b0, rst_pin_n = 1'b0, brownout_low = 1'b0, brownout_reset_enable = 1'b0;
  reg brownout_int_enable = 1'b1, system_reset_request = 1'b0, wdt_enable = 1'b0, wdt_reset_enable = 1'b0;
  reg wdt_int_clear = 1'b0, osc_check_enable = 1'b0, main_osc_bad = 1'b0, cause_clear = 1'b0;
  reg [`SRSTC_PERIPH_W-1:0] peripheral_reset_regs_0 = 32'h0, peripheral_reset_regs_1 = 32'h0;
  reg [`SRSTC_PERIPH_W-1:0] peripheral_reset_regs_2 = 32'h0;
  reg [31:0] watchdog_reload_value = 32'h10;
  reg [`SRSTC_CAUSE_W-1:0] cause_clear_mask = 6'h00;
  reg [2:0] ident_sel = 3'h0;
  reg [1:0] lat = 2'h0;
  wire fetch_done, core_reset_n, jtag_reset_n, nmi_boot, brownout_int, wdt_int;
  wire [`SRSTC_PERIPH_W-1:0] periph_reset_0_n, periph_reset_1_n, periph_reset_2_n;
  wire [`SRSTC_CAUSE_W-1:0] reset_cause_reg;
  wire [2:0] boot_state;
  wire [31:0] wdt_count, ident_data;
  integer n_mismatch = 0, samples_checked = 0, exp_cause = 0, i, k, b, seen;
  // 100 ns clock
  always #50 mclk = ~mclk;
  srstc_top dut_u (.mclk, .reset_n, .rst_pin_n, .brownout_low, .brownout_reset_enable, .brownout_int_enable,
    .system_reset_request, .peripheral_reset_regs_0, .peripheral_reset_regs_1, .peripheral_reset_regs_2,
    .watchdog_reload_value, .wdt_enable, .wdt_reset_enable, .wdt_int_clear, .osc_check_enable, .main_osc_bad,
    .cause_clear, .cause_clear_mask, .ident_sel, .fetch_done, .core_reset_n, .jtag_reset_n, .periph_reset_0_n,
    .periph_reset_1_n, .periph_reset_2_n, .reset_cause_reg, .boot_state, .nmi_boot, .brownout_int, .wdt_int,
    .wdt_count, .ident_data);
  srstc_core_model core_u (.mclk, .reset_n, .boot_state, .lat, .fetch_done);
  task chk(input string what, input [31:0] exp, input [31:0] got);
    begin
      samples_checked = samples_checked + 1;
      if (got !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
    end
  endtask
  // bounded waits: never hang on a dead sequencer
  task wait_low(input integer lim);
    begin
      @(negedge mclk);
      for (i = 0; i < lim && core_reset_n !== 1'b0; i = i + 1) @(negedge mclk);
      chk("core_reset_n", 0, core_reset_n);
    end
  endtask
  task boot_ok;
    begin
      lat = $urandom % 4;
      for (i = 0; i < 80 && boot_state !== `SRSTC_ST_RUN; i = i + 1) @(negedge mclk);
      chk("boot_state", `SRSTC_ST_RUN, boot_state);
      chk("reset_cause_reg", exp_cause, reset_cause_reg);
    end
  endtask
  task summarize;
    begin
      $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
    end
  endtask
  initial begin
    #300000;
    n_mismatch = n_mismatch + 1;
    summarize;
  end
  initial begin
    i = $urandom(32);
    @(negedge mclk);
    chk("por cause", 32'h02, reset_cause_reg);
    chk("jtag_reset_n", 0, jtag_reset_n);
    repeat (2) @(posedge mclk);
    reset_n <= 1'b1;
    // pin outlasts power-on: reset must wait for the later one
    repeat (20) @(negedge mclk);
    chk("held by pin", 0, core_reset_n);
    @(posedge mclk) rst_pin_n <= 1'b1;
    exp_cause = 2;
    boot_ok;
    for (k = 0; k < 2; k = k + 1) begin
      @(posedge mclk) ident_sel <= k[2:0];
      @(posedge mclk);
      @(negedge mclk) chk("ident_data", k ? `SRSTC_IDENT_1 : `SRSTC_IDENT_0, ident_data);
    end
    @(posedge mclk) {cause_clear, cause_clear_mask} <= 7'h7F;
    @(posedge mclk) cause_clear <= 1'b0;
    exp_cause = 0;
    @(negedge mclk) chk("cleared cause", 0, reset_cause_reg);
    // pin reset of random length, test port untouched
    @(posedge mclk) rst_pin_n <= 1'b0;
    repeat (5 + $urandom % 8) @(posedge mclk);
    @(negedge mclk);
    chk("core_reset_n", 0, core_reset_n);
    chk("jtag_reset_n", 1, jtag_reset_n);
    @(posedge mclk) rst_pin_n <= 1'b1;
    exp_cause = 1;
    boot_ok;
    // brown-out: interrupt only when reset disabled, then resets while low
    for (k = 0; k < 2; k = k + 1) begin
      @(posedge mclk) brownout_reset_enable <= k;
      repeat (4) @(posedge mclk);
      brownout_low <= 1'b1;
      repeat (6 + $urandom % 6) @(posedge mclk);
      @(negedge mclk);
      chk("bor core_reset_n", !k, core_reset_n);
      chk("brownout_int", !k, brownout_int);
      @(posedge mclk) brownout_low <= 1'b0;
    end
    exp_cause = 5;
    boot_ok;
    @(posedge mclk) brownout_reset_enable <= 1'b0;
    // whole-system software request
    @(posedge mclk) system_reset_request <= 1'b1;
    repeat (4) @(posedge mclk);
    system_reset_request <= 1'b0;
    exp_cause = 21;
    wait_low(4);
    boot_ok;
    // peripheral set-then-clear pulses, bit 0 and a random bit
    for (k = 0; k < 2; k = k + 1) begin
      b = k ? $urandom % 32 : 0;
      @(posedge mclk) {peripheral_reset_regs_0[b], peripheral_reset_regs_1[b], peripheral_reset_regs_2[b]} <= 3'h7;
      repeat (2) @(posedge mclk);
      {peripheral_reset_regs_0[b], peripheral_reset_regs_1[b], peripheral_reset_regs_2[b]} <= 3'h0;
      seen = 0;
      repeat (4) @(negedge mclk) if (!periph_reset_0_n[b] && !periph_reset_1_n[b] && !periph_reset_2_n[b]) seen = 1;
      chk("periph pulse", 1, seen);
    end
    // oscillator fault ignored without check, then resets
    @(posedge mclk) main_osc_bad <= 1'b1;
    repeat (6) @(negedge mclk);
    chk("osc off core", 1, core_reset_n);
    @(posedge mclk) osc_check_enable <= 1'b1;
    wait_low(10);
    @(posedge mclk) {osc_check_enable, main_osc_bad} <= 2'h0;
    exp_cause = 53;
    boot_ok;
    chk("nmi_boot", 1, nmi_boot);
    // watchdog: interrupt on first zero, cleared, again on second, reset on third
    @(posedge mclk) watchdog_reload_value <= 16 + $urandom % 16;
    {wdt_enable, wdt_reset_enable} <= 2'h3;
    for (i = 0; i < 100 && wdt_int !== 1'b1; i = i + 1) @(negedge mclk);
    chk("wdt_int", 1, wdt_int);
    chk("wdt_count", watchdog_reload_value, wdt_count);
    // a cleared first interrupt turns the next zero into a first time-out again
    @(posedge mclk) wdt_int_clear <= 1'b1;
    @(posedge mclk) wdt_int_clear <= 1'b0;
    @(negedge mclk);
    for (i = 0; i < 100 && wdt_int !== 1'b1; i = i + 1) @(negedge mclk);
    chk("wdt cleared core", 1, core_reset_n);
    wait_low(60);
    @(posedge mclk) wdt_enable <= 1'b0;
    exp_cause = 61;
    boot_ok;
    chk("nmi_boot", 0, nmi_boot);
    // second power-on with pin high: release timing and power-on flag alone
    @(posedge mclk) reset_n <= 1'b0;
    @(negedge mclk) chk("por jtag_reset_n", 0, jtag_reset_n);
    @(posedge mclk) reset_n <= 1'b1;
    for (i = 0; i < 40 && core_reset_n !== 1'b1; i = i + 1) @(negedge mclk);
    chk("release cycles", `SRSTC_HOLD_CYC + 5, i);
    exp_cause = 2;
    boot_ok;
    summarize;
  end
endmodule
